// *** hdl/exc_seq_defs.vh ***
// Purpose: constants for the exception sequencer
// Assumes: included by bare name
// Notes:   offsets are byte addresses of the register bus
`ifndef EXC_SEQ_DEFS_VH
`define EXC_SEQ_DEFS_VH

// register byte offsets
`define OFS_CSW        8'h00
`define OFS_SSW        8'h04
`define OFS_STATUS     8'h08

// status word field positions
`define BIT_T          5
`define BIT_F          6
`define BIT_I          7
`define MODE_HI        4
`define MODE_LO        0
`define FLAG_HI        31
`define FLAG_LO        28

// reset value of the current status word: supervisor, masks set
`define CSW_RESET      32'h000000D3

// mode encodings
`define MODE_USR       5'h10
`define MODE_FIQ       5'h11
`define MODE_IRQ       5'h12
`define MODE_SVC       5'h13
`define MODE_ABT       5'h17
`define MODE_UND       5'h1B
`define MODE_SYS       5'h1F

// saved-bank indices, BANK_NONE for user and system
`define BANK_FIQ       3'h0
`define BANK_IRQ       3'h1
`define BANK_SVC       3'h2
`define BANK_ABT       3'h3
`define BANK_UND       3'h4
`define BANK_NONE      3'h7

// cause codes, vector address is cause times four
`define CAUSE_RESET    3'h0
`define CAUSE_UNDEF    3'h1
`define CAUSE_SWI      3'h2
`define CAUSE_PREFETCH_ABORT     3'h3
`define CAUSE_DATA_ABORT     3'h4
`define CAUSE_IRQ      3'h6
`define CAUSE_FIQ      3'h7

// link offsets
`define LINK_ADD2      32'h00000002
`define LINK_ADD4      32'h00000004
`define LINK_ADD8      32'h00000008

// sequencer states
`define ST_BOOT        2'h0
`define ST_RUN         2'h1
`define ST_ENTER       2'h2

`endif

// *** hdl/exc_priority.v ***
// Purpose: fixed-order pick among pending exceptions
// Assumes: requests already synchronised to ref_clk
// Notes:   reset is handled by the sequencer itself
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_defs.vh"

module exc_priority
(
  // pending requests
  input  wire       data_abort_req,
  input  wire       fiq_req,
  input  wire       irq_req,
  input  wire       prefetch_abort_req,
  input  wire       undef_req,
  input  wire       swi_req,
  // masks from the current status word
  input  wire       fiq_mask,
  input  wire       irq_mask,
  // pick
  output reg        take,
  output reg  [2:0] cause
);

  always @*
  begin
    take  = 1'b1;
    cause = `CAUSE_UNDEF;
    if (data_abort_req)                       // see RULE10 see RULE11
      cause = `CAUSE_DATA_ABORT;
    else if (fiq_req && !fiq_mask)      // see RULE5
      cause = `CAUSE_FIQ;
    else if (irq_req && !irq_mask)      // see RULE5
      cause = `CAUSE_IRQ;
    else if (prefetch_abort_req)
      cause = `CAUSE_PREFETCH_ABORT;
    else if (undef_req)
      cause = `CAUSE_UNDEF;
    else if (swi_req)
      cause = `CAUSE_SWI;
    else
      take = 1'b0;
  end

endmodule // exc_priority

`default_nettype wire

// *** hdl/exc_seq.v ***
// Purpose: exception entry/exit sequencer and status-word control
// Assumes: core stalls at a boundary while busy is high
// Notes:   registers reached over AHB-Lite, zero wait states
//
// Notes on behaviour
// RULE1: control byte updated on entry, privileged writes
// RULE2: state flag selects 16-bit or 32-bit state
// RULE3: state indicator output mirrors current flag
// RULE4: software never writes current state flag; privileged CSW writes here still load it
// RULE5: masks block normal and fast interrupts
// RULE6: five-bit mode field encodes seven modes
// RULE7: software programs only listed mode encodings
// RULE8: mode selects banked registers and saved word
// RULE9: software preserves reserved status bits
// RULE10: simultaneous exceptions serviced in fixed order
// RULE11: reset, data_abort, fiq, irq, prefetch_abort, undef/trap
// RULE12: link written first, adjusted by state
// RULE13: current word copied into target saved word
// RULE14: mode forced to exception's target mode
// RULE15: fetch redirected to the exception vector
// RULE16: entry may set interrupt masks
// RULE17: fast-interrupt entry also sets normal mask
// RULE18: reset release enters supervisor at zero
// RULE19: entry switches to 32-bit state
// RULE20: exit loads link minus offset, restores word
// RULE21: restore brings back the state flag
// RULE22: link-branch, trap, undefined: plus four or two
// RULE23: interrupts: plus four in either state
// RULE24: data abort plus eight, prefetch plus four
// RULE25: handlers return with recommended offsets
// RULE26: reset link value is undefined
// RULE27: entry sequence happens in one indivisible step
`timescale 1ns/10ps
`default_nettype none
`include "exc_seq_defs.vh"

module exc_seq
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // interrupt pins, active low, asynchronous
  input  wire        irq_n,
  input  wire        fiq_n,
  // pipeline side
  input  wire        inst_boundary,
  input  wire [31:0] exc_pc,
  input  wire        undefined_trap,
  input  wire        software_trap,
  input  wire        prefetch_abort,
  input  wire        data_abort,
  input  wire        branch_with_link,
  input  wire        exit_req,
  input  wire [31:0] exit_link,
  input  wire [3:0]  exit_offset,
  // fetch redirect and link write
  output wire        redirect_valid,
  output wire [31:0] redirect_addr,
  output wire        link_write,
  output wire [2:0]  link_bank,
  output wire [31:0] link_value,
  // status view
  output wire        state_indicator_output,
  output wire [4:0]  mode_out,
  output wire        irq_mask,
  output wire        fiq_mask,
  output wire        fiq_bank_hi,
  output wire [2:0]  bank_sel,
  output wire        busy
);

  // saved bank for a mode, none for user and system
  function [2:0] bank_of;
    input [4:0] m;
    begin
      case (m)                                      // see RULE8
        `MODE_FIQ: bank_of = `BANK_FIQ;
        `MODE_IRQ: bank_of = `BANK_IRQ;
        `MODE_SVC: bank_of = `BANK_SVC;
        `MODE_ABT: bank_of = `BANK_ABT;
        `MODE_UND: bank_of = `BANK_UND;
        default:   bank_of = `BANK_NONE;
      endcase
    end
  endfunction

  // target mode of an exception cause
  function [4:0] mode_of;
    input [2:0] c;
    begin
      case (c)                                      // see RULE6
        `CAUSE_UNDEF: mode_of = `MODE_UND;
        `CAUSE_PREFETCH_ABORT:  mode_of = `MODE_ABT;
        `CAUSE_DATA_ABORT:  mode_of = `MODE_ABT;
        `CAUSE_IRQ:   mode_of = `MODE_IRQ;
        `CAUSE_FIQ:   mode_of = `MODE_FIQ;
        default:      mode_of = `MODE_SVC;
      endcase
    end
  endfunction

  reg  [31:0] csw_reg;
  reg  [31:0] csw_next;
  reg  [31:0] saved_reg [0:4];
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  cause_reg;
  reg  [31:0] pc_reg;
  reg         busy_reg;
  reg         redir_reg;
  reg  [31:0] redir_addr_reg;
  reg         lwr_reg;
  reg  [2:0]  lbank_reg;
  reg  [31:0] lval_reg;
  reg  [2:0]  last_cause_reg;
  reg         fiq_hi_reg;
  reg  [2:0]  bank_sel_reg;
  reg         irq_s1_reg;
  reg         irq_s2_reg;
  reg         fiq_s1_reg;
  reg         fiq_s2_reg;
  // bus pipeline
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [31:0] hrdata_reg;
  reg         hready_reg;
  reg         hresp_reg;

  wire        take;
  wire [2:0]  pick;
  wire [2:0]  cur_bank;
  wire [2:0]  tgt_bank;
  wire        priv;
  wire        addr_ok;
  wire        ssw_ok;
  reg  [31:0] link_calc;
  reg  [31:0] rd_mux;

  assign cur_bank = bank_of(csw_reg[`MODE_HI:`MODE_LO]);
  assign tgt_bank = bank_of(mode_of(cause_reg));
  assign priv     = csw_reg[`MODE_HI:`MODE_LO] != `MODE_USR;
  assign ssw_ok   = cur_bank != `BANK_NONE;

  // pins cross into ref_clk through two flops
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
      fiq_s1_reg <= 1'b0;
      fiq_s2_reg <= 1'b0;
    end
    else
    begin
      irq_s1_reg <= ~irq_n;
      irq_s2_reg <= irq_s1_reg;
      fiq_s1_reg <= ~fiq_n;
      fiq_s2_reg <= fiq_s1_reg;
    end
  end

  exc_priority u_pri
  (
    .data_abort_req  (data_abort),
    .fiq_req   (fiq_s2_reg),
    .irq_req   (irq_s2_reg),
    .prefetch_abort_req  (prefetch_abort),
    .undef_req (undefined_trap),
    .swi_req   (software_trap),
    .fiq_mask  (csw_reg[`BIT_F]),
    .irq_mask  (csw_reg[`BIT_I]),
    .take      (take),
    .cause     (pick)
  );

  // link value of the captured exception
  always @*
  begin
    link_calc = pc_reg + `LINK_ADD4;
    case (cause_reg)
      `CAUSE_UNDEF,
      `CAUSE_SWI:
        if (csw_reg[`BIT_T])                        // see RULE22 see RULE12
          link_calc = pc_reg + `LINK_ADD2;
      `CAUSE_DATA_ABORT:
        link_calc = pc_reg + `LINK_ADD8;            // see RULE24
      default:
        link_calc = pc_reg + `LINK_ADD4;            // see RULE23 see RULE24
    endcase
  end

  // sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `ST_BOOT:
        state_next = `ST_RUN;
      `ST_RUN:
        if (inst_boundary && take)
          state_next = `ST_ENTER;
      `ST_ENTER:
        state_next = `ST_RUN;
      default:
        state_next = `ST_RUN;
    endcase
  end

  // current word: entry beats exit beats a software write
  always @*
  begin
    csw_next = csw_reg;
    if (state_reg == `ST_BOOT)
    begin
      csw_next[`MODE_HI:`MODE_LO] = `MODE_SVC;      // see RULE18
      csw_next[`BIT_I] = 1'b1;
      csw_next[`BIT_F] = 1'b1;
      csw_next[`BIT_T] = 1'b0;
    end
    else if (state_reg == `ST_ENTER)
    begin
      csw_next[`MODE_HI:`MODE_LO] = mode_of(cause_reg); // see RULE14
      csw_next[`BIT_T] = 1'b0;                      // see RULE19
      csw_next[`BIT_I] = 1'b1;                      // see RULE16
      if (cause_reg == `CAUSE_FIQ)
        csw_next[`BIT_F] = 1'b1;                    // see RULE17
    end
    else if (state_reg == `ST_RUN && exit_req && !(inst_boundary && take)
             && ssw_ok)
      csw_next = saved_reg[cur_bank];               // see RULE20 see RULE21
    else if (wr_pend_reg && wr_addr_reg == `OFS_CSW && priv)
    begin
      csw_next[`FLAG_HI:`FLAG_LO] = hwdata[`FLAG_HI:`FLAG_LO];
      csw_next[7:0] = hwdata[7:0];                  // see RULE1
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= `ST_BOOT;
      csw_reg        <= `CSW_RESET;
      cause_reg      <= `CAUSE_RESET;
      pc_reg         <= 32'h00000000;
      busy_reg       <= 1'b1;
      redir_reg      <= 1'b0;
      redir_addr_reg <= 32'h00000000;
      lwr_reg        <= 1'b0;
      lbank_reg      <= `BANK_SVC;
      lval_reg       <= 32'h00000000;
      last_cause_reg <= `CAUSE_RESET;
      fiq_hi_reg     <= 1'b0;
      bank_sel_reg   <= `BANK_SVC;
    end
    else
    begin
      state_reg <= state_next;
      csw_reg   <= csw_next;
      busy_reg  <= state_next != `ST_RUN;
      redir_reg <= 1'b0;
      lwr_reg   <= 1'b0;
      // bank view follows the word it is loaded with, so no lag
      fiq_hi_reg   <= csw_next[`MODE_HI:`MODE_LO] == `MODE_FIQ;
      bank_sel_reg <= bank_of(csw_next[`MODE_HI:`MODE_LO]);   // see RULE8
      case (state_reg)
        `ST_BOOT:
        begin
          // saved pc is whatever pc_reg holds, zero from reset
          redir_reg      <= 1'b1;                   // see RULE18
          redir_addr_reg <= 32'h00000000;
          lwr_reg        <= 1'b1;                   // see RULE26
          lbank_reg      <= `BANK_SVC;
          lval_reg       <= pc_reg;
          last_cause_reg <= `CAUSE_RESET;
        end
        `ST_RUN:
          if (inst_boundary && take)
          begin
            cause_reg <= pick;
            pc_reg    <= exc_pc;
          end
          else if (exit_req)
          begin
            redir_reg      <= 1'b1;                 // see RULE20
            redir_addr_reg <= exit_link - {28'h0000000, exit_offset};
          end
          else if (inst_boundary && branch_with_link)
          begin
            lwr_reg   <= 1'b1;                      // see RULE22
            lbank_reg <= cur_bank;
            lval_reg  <= exc_pc + (csw_reg[`BIT_T] ? `LINK_ADD2
                                                   : `LINK_ADD4);
          end
        `ST_ENTER:
        begin
          // all entry effects land on this one edge
          lwr_reg        <= 1'b1;                   // see RULE27 see RULE12
          lbank_reg      <= tgt_bank;
          lval_reg       <= link_calc;
          redir_reg      <= 1'b1;                   // see RULE15
          redir_addr_reg <= {27'h0000000, cause_reg, 2'h0};
          last_cause_reg <= cause_reg;
        end
        default:
          redir_reg <= 1'b0;
      endcase
    end
  end

  // saved words: a bank is written only by boot (supervisor bank), by entry or by software
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_saved
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          saved_reg[gi] <= 32'h00000000;
        else if (state_reg == `ST_BOOT && gi == `BANK_SVC)
          saved_reg[gi] <= csw_reg;                 // see RULE18
        else if (state_reg == `ST_ENTER && tgt_bank == gi)
          saved_reg[gi] <= csw_reg;                 // see RULE13
        else if (wr_pend_reg && wr_addr_reg == `OFS_SSW && priv
                 && cur_bank == gi)
        begin
          saved_reg[gi][`FLAG_HI:`FLAG_LO] <= hwdata[`FLAG_HI:`FLAG_LO];
          saved_reg[gi][7:0] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // bus slave: address phase registered, write lands in data phase
  assign addr_ok = hsel && hready && htrans[1];

  always @*
  begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `OFS_CSW:
      begin
        rd_mux[`FLAG_HI:`FLAG_LO] = csw_next[`FLAG_HI:`FLAG_LO];
        rd_mux[7:0] = csw_next[7:0];
      end
      `OFS_SSW:
        if (ssw_ok)
        begin
          rd_mux[`FLAG_HI:`FLAG_LO] =
            saved_reg[cur_bank][`FLAG_HI:`FLAG_LO];
          rd_mux[7:0] = saved_reg[cur_bank][7:0];
        end
      `OFS_STATUS:
        rd_mux[7:0] = {busy_reg, last_cause_reg, 1'b0, cur_bank};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
      hready_reg  <= 1'b1;
      hresp_reg   <= 1'b0;
    end
    else
    begin
      hready_reg  <= 1'b1;
      hresp_reg   <= 1'b0;
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_reg <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata_reg <= rd_mux;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp     = hresp_reg;

  assign redirect_valid         = redir_reg;
  assign redirect_addr          = redir_addr_reg;
  assign link_write             = lwr_reg;
  assign link_bank              = lbank_reg;
  assign link_value             = lval_reg;
  assign state_indicator_output = csw_reg[`BIT_T];  // see RULE3 see RULE2
  assign mode_out               = csw_reg[`MODE_HI:`MODE_LO];
  assign irq_mask               = csw_reg[`BIT_I];
  assign fiq_mask               = csw_reg[`BIT_F];
  assign fiq_bank_hi            = fiq_hi_reg;
  assign bank_sel               = bank_sel_reg;
  assign busy                   = busy_reg;

  // hsize is accepted but only whole words are meaningful
  wire unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule // exc_seq

`default_nettype wire

// *** verif/exc_seq_monitor.sv ***
// Purpose: port-level checks of the exception sequencer
// Assumes: bound to exc_seq, one clock domain
// Notes:   entry checks key on the joint link and redirect pulse
`timescale 1ns/10ps
`default_nettype none

module exc_seq_monitor
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // sequencer view
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_addr,
  input wire logic        link_write,
  input wire logic [2:0]  link_bank,
  input wire logic        state_indicator_output,
  input wire logic [4:0]  mode_out,
  input wire logic        irq_mask,
  input wire logic        fiq_mask,
  input wire logic        fiq_bank_hi,
  input wire logic [2:0]  bank_sel,
  input wire logic        busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire entry = redirect_valid & link_write;

  a_boot_entry:
    assert property ($fell(rst) |-> busy ##1 (entry && !busy &&
      redirect_addr == 32'h00000000 && mode_out == 5'h13 && fiq_mask))
    else $error("boot entry wrong");
  a_pulse_single:
    assert property (redirect_valid |=> !redirect_valid)
    else $error("redirect held");
  a_busy_bounded:
    assert property (busy |-> ##[1:4] !busy)
    else $error("busy stuck");
  a_user_bank:
    assert property (mode_out == 5'h10 |-> bank_sel == 3'h7 && !fiq_bank_hi)
    else $error("user bank wrong");
  a_fiq_bank:
    assert property (mode_out == 5'h11 |-> fiq_bank_hi && bank_sel == 3'h0)
    else $error("fiq bank wrong");
  a_entry_arm:
    assert property (entry |-> !state_indicator_output && irq_mask)
    else $error("entry state wrong");
  a_fiq_entry:
    assert property (entry && redirect_addr == 32'h0000001C |->
      mode_out == 5'h11 && irq_mask && fiq_mask)
    else $error("fiq entry wrong");
  a_irq_entry:
    assert property (entry && redirect_addr == 32'h00000018 |->
      mode_out == 5'h12 && link_bank == 3'h1)
    else $error("irq entry wrong");
  a_data_abort_entry:
    assert property (entry && redirect_addr == 32'h00000010 |->
      mode_out == 5'h17 && link_bank == 3'h3)
    else $error("data_abort entry wrong");
  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("bus answer wrong");
endmodule // exc_seq_monitor

`default_nettype wire

// *** verif/exc_src_model.sv ***
// Purpose: pipeline, abort and interrupt sources facing the sequencer
// Assumes: tasks called from the bench, drives after rising edges
// Notes:   released data lines are inverted, never left stale
`timescale 1ns/10ps
`default_nettype none

module exc_src_model
(
  // clock
  input  wire logic        ref_clk,
  // interrupt pins
  output var  logic        irq_n,
  output var  logic        fiq_n,
  // pipeline side
  output var  logic        inst_boundary,
  output var  logic [31:0] exc_pc,
  output var  logic        undefined_trap,
  output var  logic        software_trap,
  output var  logic        prefetch_abort,
  output var  logic        data_abort,
  output var  logic        branch_with_link,
  output var  logic        exit_req,
  output var  logic [31:0] exit_link,
  output var  logic [3:0]  exit_offset
);
  initial
  begin
    {irq_n, fiq_n} = 2'h3;
    {inst_boundary, exit_req} = 2'h0;
    {branch_with_link, data_abort, prefetch_abort} = 3'h0;
    {undefined_trap, software_trap} = 2'h0;
    exc_pc = 32'h00000000;
    exit_link = 32'h00000000;
    exit_offset = 4'h0;
  end

  // ev is {link-branch, data abort, prefetch abort, undefined, trap}
  task automatic step(input logic [4:0] ev, input logic [31:0] pc);
    @(posedge ref_clk);
    inst_boundary <= 1'b1;
    {branch_with_link, data_abort, prefetch_abort, undefined_trap,
     software_trap} <= ev;
    exc_pc <= pc;
    @(posedge ref_clk);
    inst_boundary <= 1'b0;
    {branch_with_link, data_abort, prefetch_abort, undefined_trap,
     software_trap} <= 5'h00;
    exc_pc <= ~pc;
  endtask

  // three edges let the level through the pin synchroniser
  task automatic pins(input logic i, input logic f);
    @(posedge ref_clk);
    irq_n <= i;
    fiq_n <= f;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic ret(input logic [31:0] lnk, input logic [3:0] off);
    @(posedge ref_clk);
    exit_req <= 1'b1;
    exit_link <= lnk;
    exit_offset <= off;
    @(posedge ref_clk);
    exit_req <= 1'b0;
    exit_link <= ~lnk;
    exit_offset <= ~off;
  endtask
endmodule // exc_src_model

`default_nettype wire

// *** verif/exc_seq_tb_top.sv ***
// Purpose: register and exception sequence bench for exc_seq
// Assumes: zero-wait bus slave, one clock
// Notes:   exception checks sampled on falling edges, register reads right after rising edges
`timescale 1ns/10ps
`default_nettype none

module exc_seq_tb_top;
  logic        ref_clk, rst, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire         hready, hreadyout, hresp, irq_n, fiq_n, inst_boundary;
  wire         undefined_trap, software_trap, prefetch_abort, data_abort;
  wire         branch_with_link, exit_req, redirect_valid, link_write;
  wire         state_indicator_output, irq_mask, fiq_mask;
  wire         fiq_bank_hi, busy;
  wire  [31:0] hrdata, exc_pc, exit_link, redirect_addr, link_value;
  wire  [3:0]  exit_offset;
  wire  [2:0]  link_bank, bank_sel;
  wire  [4:0]  mode_out;
  int          num_errors, samples_checked;
  logic [4:0]  modes [6] = '{5'h11, 5'h12, 5'h17, 5'h1B, 5'h1F, 5'h10};
  logic [2:0]  banks [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7, 3'h7};

  assign hready = hreadyout;
  exc_seq       exc_seq_inst       (.*);
  exc_src_model exc_src_model_inst (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    num_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1)
      hang;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rd, e);
  endtask

  // waits for a redirect, or for a link write when bl is set
  task automatic go(input logic bl, input logic [31:0] a,
                    input logic [31:0] l, input logic [4:0] m);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while ((bl ? link_write : redirect_valid) !== 1'b1 && n < 16);
    if ((bl ? link_write : redirect_valid) !== 1'b1)
      hang;
    check(redirect_addr, a);
    // entries and link-branches write the link, exits never do
    check({31'h0, link_write}, {31'h0, l != 32'h0});
    if (l != 32'h0)
      check(link_value, l);
    check({27'h0, mode_out}, {27'h0, m});
  endtask

  initial
  begin
    rst = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(8'h00, 32'h000000D3);
    rdchk(8'h0C, 32'h00000000);
    bus(1'b1, 8'h04, 32'h00000030);
    exc_src_model_inst.ret(32'h00000200, 4'h0);
    go(1'b0, 32'h00000200, 32'h0, 5'h10);
    check({31'h0, state_indicator_output}, 32'h1);
    bus(1'b1, 8'h00, 32'h000000D3);
    rdchk(8'h00, 32'h00000030);
    exc_src_model_inst.step(5'h01, 32'h00000200);
    go(1'b0, 32'h00000008, 32'h00000202, 5'h13);
    rdchk(8'h04, 32'h00000030);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, 8'h00, {24'h0, 3'h6, modes[i]});
      rdchk(8'h00, {24'h0, 3'h6, modes[i]});
      check({29'h0, bank_sel}, {29'h0, banks[i]});
    end
    exc_src_model_inst.pins(1'b0, 1'b1);
    exc_src_model_inst.step(5'h00, 32'h00000300);
    repeat (4) @(negedge ref_clk);
    check({27'h0, mode_out}, 32'h00000010);
    exc_src_model_inst.step(5'h02, 32'h00000300);
    go(1'b0, 32'h00000004, 32'h00000304, 5'h1B);
    bus(1'b1, 8'h00, 32'h0000001B);
    exc_src_model_inst.step(5'h00, 32'h00000400);
    go(1'b0, 32'h00000018, 32'h00000404, 5'h12);
    rdchk(8'h04, 32'h0000001B);
    exc_src_model_inst.pins(1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h00000012);
    exc_src_model_inst.step(5'h0C, 32'h00000500);
    go(1'b0, 32'h00000010, 32'h00000508, 5'h17);
    exc_src_model_inst.step(5'h00, 32'h00000600);
    go(1'b0, 32'h0000001C, 32'h00000604, 5'h11);
    exc_src_model_inst.pins(1'b1, 1'b1);
    exc_src_model_inst.step(5'h04, 32'h00000700);
    go(1'b0, 32'h0000000C, 32'h00000704, 5'h17);
    exc_src_model_inst.step(5'h10, 32'h00000800);
    go(1'b1, 32'h0000000C, 32'h00000804, 5'h17);
    exc_src_model_inst.ret(32'h00000904, 4'h4);
    go(1'b0, 32'h00000900, 32'h0, 5'h11);
    rdchk(8'h00, 32'h000000D1);
    rdchk(8'h08, 32'h00000030);
    tally_and_finish;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    hang;
  end
endmodule // exc_seq_tb_top

bind exc_seq exc_seq_monitor exc_seq_monitor_inst (.*);

`default_nettype wire
